/* verilog/oba_pkg.sv */
package oba_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  // Extra wait per enabled channel in the conversion scan
  localparam int CONV_US = 40;
  localparam int CONV_CYC_DFLT = CONV_US * CLK_MHZ;
  localparam int NV_PROG_CYC_DFLT = 16;
  // ----------------------------------------------------------------
  // Register offsets and command fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [7:0] ADDR_OUTS = 8'h10;
  localparam logic [7:0] ADDR_CONV = 8'h14;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SEL_LSB = 4;
  localparam int CMD_FLAG_BIT = 8;
  localparam int CMD_GAIN_LSB = 12;
  localparam int ST_ERR = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SKIP = 2;
  localparam logic [3:0] BANK_BOTH = 4'h0;
  localparam logic [3:0] BANK_LO = 4'h1;
  localparam logic [3:0] BANK_HI = 4'h2;
  localparam logic [3:0] LAST_CH = 4'h3;
  localparam logic [1:0] DIFF_CH = 2'h3;
  // ----------------------------------------------------------------
  // Nonvolatile words and values after reset
  // ----------------------------------------------------------------
  localparam int NV_WORDS = 9;
  localparam logic [3:0] NV_SAFE_IDX = 4'h0;
  localparam logic [3:0] NV_GAIN_IDX = 4'h1;
  localparam logic [3:0] NV_OFFS_IDX = 4'h5;
  localparam logic [15:0] SAFE_RST = 16'h0000;
  localparam logic [15:0] GAIN_DFLT = 16'h1000;
  localparam logic [15:0] OFFS_DFLT = 16'h0000;
  localparam logic [15:0] CONVERSION_OVERFLOW_MARKER = 16'hF000;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    SINGLE_OUTPUT_WRITE_CMD = 4'h1,
    OUTPUT_BANK_WRITE_CMD = 4'h2,
    SAFE_STATE_PROGRAM_CMD = 4'h3,
    CONVERSION_MODE_CMD = 4'h4,
    RAW_CONVERSION_READ_CMD = 4'h5,
    CAL_WRITE_CMD = 4'h6,
    CARD_HARDWARE_RESET_CMD = 4'h7,
    RESET_REGISTER_READ_CMD = 4'h8
  } oba_op_t;
  typedef enum logic [1:0] {
    S_BOOT = 2'b00,
    S_IDLE = 2'b01,
    S_RDWAIT = 2'b10
  } oba_state_t;
endpackage : oba_pkg

/* verilog/oba_ifs.sv */
`timescale 1ns/1ps
interface oba_nv_if;
  logic wr;
  logic [3:0] idx;
  logic [15:0] wdata;
  logic busy;
  logic [oba_pkg::NV_WORDS-1:0][15:0] words;
  modport store (input wr, idx, wdata, output busy, words);
  modport user (output wr, idx, wdata, input busy, words);
endinterface : oba_nv_if

interface oba_conv_if;
  logic [3:0] en;
  logic [3:0] take;
  logic [3:0][9:0] raw_in;
  logic [3:0] ovr_in;
  logic [3:0][9:0] res;
  logic [3:0] res_ovr;
  logic [3:0] fresh;
  logic [1:0] ch;
  modport sched (input en, take, raw_in, ovr_in,
                 output res, res_ovr, fresh, ch);
  modport ctrl (output en, take, raw_in, ovr_in,
                input res, res_ovr, fresh, ch);
endinterface : oba_conv_if

/* verilog/oba_nvstore.sv */
`timescale 1ns/1ps
module oba_nvstore import oba_pkg::*; #(
  parameter int PROG_CYC = NV_PROG_CYC_DFLT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Store port
  oba_nv_if.store nv
);
  typedef struct packed {
    logic [NV_WORDS-1:0][15:0] mem;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic [15:0] data;
  } oba_nv_t;
  // Power-up only: a card reset does not touch this store
  localparam oba_nv_t NV_RST = '{
    mem: {{4{OFFS_DFLT}}, {4{GAIN_DFLT}}, SAFE_RST},
    cnt: 16'h0000, idx: 4'h0, data: 16'h0000};
  oba_nv_t r_reg;
  oba_nv_t r_next;

  always_comb begin
    r_next = r_reg;
    if (r_reg.cnt != 16'h0000) begin
      r_next.cnt = r_reg.cnt - 16'h0001;
      if (r_reg.cnt == 16'h0001) begin
        r_next.mem[r_reg.idx] = r_reg.data;
      end
    end else if (nv.wr && r_reg.mem[nv.idx] != nv.wdata) begin
      r_next.cnt = 16'(PROG_CYC);
      r_next.idx = nv.idx;
      r_next.data = nv.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= NV_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign nv.busy = r_reg.cnt != 16'h0000;
  assign nv.words = r_reg.mem;

  nv_skip_a: assert property (@(posedge i_clk) disable iff (i_rst)
    nv.wr && !nv.busy && r_reg.mem[nv.idx] == nv.wdata
    |=> !nv.busy && r_reg.mem == $past(r_reg.mem))
    else $error("matching word was programmed");
  nv_commit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    r_reg.cnt == 16'h0001
    |=> r_reg.mem[$past(r_reg.idx)] == $past(r_reg.data) && !nv.busy)
    else $error("programmed word not stored");
endmodule : oba_nvstore

/* verilog/oba_convsched.sv */
`timescale 1ns/1ps
module oba_convsched import oba_pkg::*; #(
  parameter int CONV_CYC = CONV_CYC_DFLT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Conversion port
  oba_conv_if.sched cv
);
  typedef struct packed {
    logic [1:0] ch;
    logic [15:0] cnt;
    logic [3:0][9:0] res;
    logic [3:0] ovr;
    logic [3:0] fresh;
  } oba_cs_t;
  oba_cs_t r_reg;
  oba_cs_t r_next;

  // Next enabled channel after c; stays on c when no other is enabled
  function automatic logic [1:0] next_ch(input logic [1:0] c,
                                         input logic [3:0] en);
    logic [1:0] k;
    next_ch = c;
    for (int i = 3; i >= 1; i--) begin
      k = c + 2'(i);
      if (en[k]) begin
        next_ch = k;
      end
    end
  endfunction : next_ch

  always_comb begin
    r_next = r_reg;
    // A conversion that completes as the reader takes it stays fresh
    r_next.fresh = r_reg.fresh & ~cv.take;
    if (!cv.en[r_reg.ch]) begin
      r_next.ch = next_ch(r_reg.ch, cv.en);
      r_next.cnt = 16'h0000;
    end else if (r_reg.cnt == 16'(CONV_CYC - 1)) begin
      r_next.res[r_reg.ch] = cv.raw_in[r_reg.ch];
      r_next.ovr[r_reg.ch] = cv.ovr_in[r_reg.ch];
      r_next.fresh[r_reg.ch] = 1'b1;
      r_next.ch = next_ch(r_reg.ch, cv.en);
      r_next.cnt = 16'h0000;
    end else begin
      r_next.cnt = r_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cv.res = r_reg.res;
  assign cv.res_ovr = r_reg.ovr;
  assign cv.fresh = r_reg.fresh;
  assign cv.ch = r_reg.ch;

  conv_fresh_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cv.en[r_reg.ch] && r_reg.cnt == 16'(CONV_CYC - 1)
    |=> r_reg.fresh[$past(r_reg.ch)]
      && r_reg.res[$past(r_reg.ch)] == $past(cv.raw_in[r_reg.ch]))
    else $error("finished conversion not stored");
  scan_skip_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !cv.en[r_reg.ch] && cv.en != 4'h0
    |=> r_reg.cnt == 16'h0000 && r_reg.ch != $past(r_reg.ch)
      && ($past(cv.en) & (4'h1 << r_reg.ch)) != 4'h0)
    else $error("scan stayed on a disabled channel");
endmodule : oba_convsched

/* verilog/oba_card_ctrl.sv */
// How it works
// - All output drivers are off from power-up until a safe state applies.
// - Safe word bit per channel: zero disables sourcing, one sinking.
// - Safe word comes up all zero, so sourcing stays disabled.
// - A new safe word equal to the stored one is not programmed.
// - Single-output command sets or clears the named channel 0 to 15.
// - Bank code 0 writes all sixteen, 1 channels 0-7, 2 channels 8-15.
// - Single bank uses data bits 7:0; both banks map bit n to channel n.
// - Each analog channel has its own conversion on or off mode.
// - Analog channels 0 to 2 are single-ended; channel 3 is differential.
// - Raw results are unsigned 10-bit values 0 to 1023.
// - Each read waits for a fresh conversion; wait grows with channels.
// - Overflow is flagged and the result replaced by the -4096 marker.
// - Gain and offset per channel are stored, factory preset, host writable.
// - Each response carries the status of the previous command.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module oba_card_ctrl import oba_pkg::*; #(
  parameter int CONV_CYC = CONV_CYC_DFLT,
  parameter int NV_PROG_CYC = NV_PROG_CYC_DFLT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Output drivers
  output logic [15:0] o_out_level,
  output logic [15:0] o_src_oe,
  output logic [15:0] o_snk_oe,
  // Analog front end
  input wire logic [3:0][9:0] i_adc_raw,
  input wire logic [3:0] i_adc_ovr,
  output logic [1:0] o_adc_ch,
  output logic o_adc_diff
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    oba_state_t st;
    logic drv_on;
    logic [15:0] safe_act;
    logic [15:0] out_lv;
    logic [15:0] src_oe;
    logic [15:0] snk_oe;
    logic [31:0] data;
    logic [16:0] result;
    logic [7:0] last_st;
    logic [7:0] resp_st;
    logic rst_flag;
    logic [3:0] conv_en;
    logic [1:0] rd_ch;
    logic [31:0] rdata;
    logic nv_wr;
    logic [3:0] nv_idx;
    logic [15:0] nv_wdata;
    logic [3:0] take;
    logic [1:0] adc_ch;
    logic adc_diff;
  } oba_top_t;

  oba_top_t r_reg;
  oba_top_t r_next;
  logic [7:0] cst;
  oba_op_t op;
  logic [3:0] sel;
  logic flag;
  logic [3:0] gain;
  logic cmd_wr;

  oba_nv_if nv();
  oba_conv_if cv();

  assign op = oba_op_t'(i_wdata[CMD_OP_LSB +: 4]);
  assign sel = i_wdata[CMD_SEL_LSB +: 4];
  assign flag = i_wdata[CMD_FLAG_BIT];
  assign gain = i_wdata[CMD_GAIN_LSB +: 4];
  assign cmd_wr = i_wr && i_addr == ADDR_CMD;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  oba_nvstore #(
    .PROG_CYC(NV_PROG_CYC)
  ) u_nv (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .nv(nv.store)
  );

  oba_convsched #(
    .CONV_CYC(CONV_CYC)
  ) u_sched (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .cv(cv.sched)
  );

  assign nv.wr = r_reg.nv_wr;
  assign nv.idx = r_reg.nv_idx;
  assign nv.wdata = r_reg.nv_wdata;
  assign cv.en = r_reg.conv_en;
  assign cv.take = r_reg.take;
  assign cv.raw_in = i_adc_raw;
  assign cv.ovr_in = i_adc_ovr;

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.nv_wr = 1'b0;
    r_next.take = 4'h0;
    r_next.rdata = 32'h0000_0000;
    cst = 8'h00;
    unique case (r_reg.st)
      S_BOOT: begin
        // Waits out any programming so the newest word is applied
        if (!nv.busy) begin
          r_next.safe_act = nv.words[NV_SAFE_IDX];
          r_next.drv_on = 1'b1;
          r_next.rst_flag = 1'b1;
          r_next.st = S_IDLE;
        end
      end
      S_RDWAIT: begin
        if (cv.fresh[r_reg.rd_ch]) begin
          r_next.take[r_reg.rd_ch] = 1'b1;
          if (cv.res_ovr[r_reg.rd_ch]) begin
            r_next.result = {1'b1, CONVERSION_OVERFLOW_MARKER};
          end else begin
            r_next.result = {7'h00, cv.res[r_reg.rd_ch]};
          end
          r_next.st = S_IDLE;
        end
      end
      S_IDLE: begin
      end
      default: begin
        r_next.st = S_BOOT;
      end
    endcase

    if (i_wr && i_addr == ADDR_DATA) begin
      r_next.data = i_wdata;
    end

    if (cmd_wr) begin
      if (r_reg.st != S_IDLE) begin
        cst[ST_BUSY] = 1'b1;
      end else begin
        unique case (op)
          SINGLE_OUTPUT_WRITE_CMD: begin
            r_next.out_lv[sel] = flag;
          end
          OUTPUT_BANK_WRITE_CMD: begin
            case (sel)
              BANK_BOTH: r_next.out_lv = r_reg.data[15:0];
              BANK_LO: r_next.out_lv[7:0] = r_reg.data[7:0];
              BANK_HI: r_next.out_lv[15:8] = r_reg.data[7:0];
              default: cst[ST_ERR] = 1'b1;
            endcase
          end
          SAFE_STATE_PROGRAM_CMD: begin
            if (nv.busy) begin
              cst[ST_BUSY] = 1'b1;
            end else begin
              r_next.nv_wr = 1'b1;
              r_next.nv_idx = NV_SAFE_IDX;
              r_next.nv_wdata = r_reg.data[15:0];
              cst[ST_SKIP] =
                nv.words[NV_SAFE_IDX] == r_reg.data[15:0];
            end
          end
          CONVERSION_MODE_CMD: begin
            if (gain != 4'h0 || sel > LAST_CH) begin
              cst[ST_ERR] = 1'b1;
            end else begin
              r_next.conv_en[sel[1:0]] = flag;
              // A result left over from before must not count as new
              r_next.take[sel[1:0]] = 1'b1;
            end
          end
          RAW_CONVERSION_READ_CMD: begin
            if (sel > LAST_CH || !r_reg.conv_en[sel[1:0]]) begin
              cst[ST_ERR] = 1'b1;
            end else begin
              r_next.rd_ch = sel[1:0];
              r_next.st = S_RDWAIT;
            end
          end
          CAL_WRITE_CMD: begin
            if (gain != 4'h0 || sel > LAST_CH) begin
              cst[ST_ERR] = 1'b1;
            end else if (nv.busy) begin
              cst[ST_BUSY] = 1'b1;
            end else begin
              r_next.nv_wr = 1'b1;
              r_next.nv_idx = (flag ? NV_OFFS_IDX : NV_GAIN_IDX) + sel;
              r_next.nv_wdata = r_reg.data[15:0];
            end
          end
          CARD_HARDWARE_RESET_CMD: begin
            r_next.st = S_BOOT;
            r_next.drv_on = 1'b0;
            r_next.out_lv = 16'h0000;
            r_next.conv_en = 4'h0;
            r_next.take = 4'hF;
          end
          RESET_REGISTER_READ_CMD: begin
            r_next.result = {16'h0000, r_reg.rst_flag};
            r_next.rst_flag = 1'b0;
          end
          default: begin
            cst[ST_ERR] = 1'b1;
          end
        endcase
      end
      r_next.resp_st = r_reg.last_st;
      r_next.last_st = cst;
    end

    if (i_rd) begin
      case (i_addr)
        ADDR_DATA: r_next.rdata = r_reg.data;
        ADDR_STATUS: r_next.rdata = {24'h00_0000, r_reg.resp_st};
        ADDR_RESULT: r_next.rdata = {15'h0000, r_reg.result};
        ADDR_OUTS: r_next.rdata = {r_reg.safe_act, r_reg.out_lv};
        ADDR_CONV: r_next.rdata = {22'h00_0000, r_reg.st, cv.fresh,
                                   r_reg.conv_en};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end

    // Drivers stay off until a safe word is applied
    r_next.src_oe = r_next.drv_on ? r_next.safe_act : 16'h0000;
    r_next.snk_oe = r_next.drv_on ? ~r_next.safe_act : 16'h0000;
    r_next.adc_ch = cv.ch;
    r_next.adc_diff = cv.ch == DIFF_CH;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_rdata = r_reg.rdata;
  assign o_out_level = r_reg.out_lv;
  assign o_src_oe = r_reg.src_oe;
  assign o_snk_oe = r_reg.snk_oe;
  assign o_adc_ch = r_reg.adc_ch;
  assign o_adc_diff = r_reg.adc_diff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence cmd_ok(oba_op_t o);
    cmd_wr && op == o && r_reg.st == S_IDLE;
  endsequence

  // Codes above the last defined op are refused as well as code zero
  sequence bad_cmd;
    cmd_wr && r_reg.st == S_IDLE
      && (op == OP_NONE || op > RESET_REGISTER_READ_CMD);
  endsequence

  hiz_boot_a: assert property (
    r_reg.st == S_BOOT |-> r_reg.src_oe == 16'h0000
      && r_reg.snk_oe == 16'h0000)
    else $error("drivers on before safe state");
  safe_drive_a: assert property (
    r_reg.drv_on |-> r_reg.src_oe == r_reg.safe_act
      && r_reg.snk_oe == ~r_reg.safe_act)
    else $error("driver enables differ from safe word");
  card_reset_a: assert property (
    cmd_ok(CARD_HARDWARE_RESET_CMD) |=> r_reg.st == S_BOOT
      && r_reg.src_oe == 16'h0000 && r_reg.out_lv == 16'h0000)
    else $error("card reset did not restart outputs");
  single_out_a: assert property (
    cmd_ok(SINGLE_OUTPUT_WRITE_CMD)
    |=> r_reg.out_lv[$past(sel)] == $past(flag))
    else $error("single output not written");
  bank_lo_a: assert property (
    cmd_ok(OUTPUT_BANK_WRITE_CMD) ##0 sel == BANK_LO
    |=> r_reg.out_lv == {$past(r_reg.out_lv[15:8]),
                         $past(r_reg.data[7:0])})
    else $error("low bank write wrong");
  status_chain_a: assert property (
    cmd_wr && r_reg.last_st[ST_ERR] |=> r_reg.resp_st[ST_ERR])
    else $error("response lacks previous status");
  bad_status_a: assert property (
    bad_cmd |=> r_reg.last_st == 8'h01)
    else $error("refused op not recorded as error");
  ovr_marker_a: assert property (
    r_reg.st == S_RDWAIT && cv.fresh[r_reg.rd_ch]
      && cv.res_ovr[r_reg.rd_ch]
    |=> r_reg.result == {1'b1, CONVERSION_OVERFLOW_MARKER}
      && r_reg.st == S_IDLE)
    else $error("overflow marker missing");
endmodule : oba_card_ctrl

/* dv/oba_host_model.sv */
`timescale 1ns/1ps
module oba_host_model import oba_pkg::*; (
  // Clock
  input wire logic i_clk,
  // Register port towards the card
  input wire logic [31:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : bus_rd

  // Gain code is always zero: the card offers no other input range
  task automatic send_cmd(input logic [3:0] op, input logic [3:0] sel,
                          input logic flag, input logic [15:0] d);
    bus_wr(ADDR_DATA, {16'h0000, d});
    bus_wr(ADDR_CMD, {16'h0000, 4'h0, 3'h0, flag, sel, op});
  endtask : send_cmd
endmodule : oba_host_model

/* dv/oba_card_ctrl_tb.sv */
`timescale 1ns/1ps
module oba_card_ctrl_tb;
  import oba_pkg::*;
  // Short conversion slot keeps the run brief
  localparam int CONV_N = 20;
  logic clk, rst, wr, rd, adc_diff, seen;
  logic diff_seen = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] lvl, src_oe, snk_oe;
  logic [3:0][9:0] adc_raw;
  logic [3:0] adc_ovr;
  logic [1:0] adc_ch;
  int mismatches = 0;
  int total_checks = 0;

  oba_card_ctrl #(.CONV_CYC(CONV_N), .NV_PROG_CYC(4)) u_oba_card_ctrl (
    .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_out_level(lvl), .o_src_oe(src_oe),
    .o_snk_oe(snk_oe), .i_adc_raw(adc_raw), .i_adc_ovr(adc_ovr),
    .o_adc_ch(adc_ch), .o_adc_diff(adc_diff));

  oba_host_model u_oba_host_model (
    .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Compare and access helpers
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_pins(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_pins

  task automatic cmd(input logic [3:0] op, input logic [3:0] sel,
                     input logic flag, input logic [15:0] dat);
    u_oba_host_model.send_cmd(op, sel, flag, dat);
  endtask : cmd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    logic [31:0] v;
    u_oba_host_model.bus_rd(a, v);
    check_word(v, exp, what);
  endtask : rd_chk

  // Outputs follow on the same edge that takes the command
  task automatic cmd_pins(input logic [3:0] op, input logic [3:0] sel,
                          input logic flag, input logic [15:0] dat,
                          input logic [15:0] exp);
    cmd(op, sel, flag, dat);
    @(posedge clk);
    #1;
    check_pins(lvl, exp, "output levels");
  endtask : cmd_pins

  // Poll until idle, then compare the result word
  task automatic conv_read(input logic [3:0] ch, input logic [31:0] exp);
    int n;
    n = 0;
    cmd(RAW_CONVERSION_READ_CMD, ch, 1'b0, 16'h0000);
    do begin
      u_oba_host_model.bus_rd(ADDR_CONV, d);
      n++;
    end while (d[9:8] !== 2'h1 && n < 400);
    check_word({30'h0, d[9:8]}, 32'h1, "scan state");
    // A read never waits longer than one scan of the enabled channels
    check_word({31'h0, (2 * n <= $countones(d[3:0]) * CONV_N + 6)},
               32'h1, "wait");
    rd_chk(ADDR_RESULT, exp, "result");
  endtask : conv_read

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Sampled mid-cycle so the registered outputs have settled
  always @(negedge clk) begin
    if (!rst && adc_diff === 1'b1) begin
      diff_seen <= 1'b1;
      check_word({30'h0, adc_ch}, 32'h3, "diff channel");
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    adc_raw = '0;
    adc_ovr = 4'h0;
    @(posedge clk);
    #1;
    check_pins(src_oe | snk_oe, 16'h0000, "drivers in reset");
    @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check_pins(src_oe, 16'h0000, "source enables");
    check_pins(snk_oe, 16'hFFFF, "sink enables");
    rd_chk(ADDR_OUTS, 32'h0000_0000, "outs after boot");
    rd_chk(8'h20, 32'h0000_0000, "unmapped read");
    rd_chk(ADDR_CMD, 32'h0000_0000, "command read");
    $display("test boot done");

    cmd(4'hF, 4'h0, 1'b0, 16'h0000);
    cmd(SINGLE_OUTPUT_WRITE_CMD, 4'h0, 1'b0, 16'h0000);
    rd_chk(ADDR_STATUS, 32'h1 << ST_ERR, "status of bad op");
    cmd(SINGLE_OUTPUT_WRITE_CMD, 4'h0, 1'b0, 16'h0000);
    rd_chk(ADDR_STATUS, 32'h0000_0000, "status of good op");
    $display("test status done");

    cmd_pins(OUTPUT_BANK_WRITE_CMD, BANK_BOTH, 1'b0, 16'h1234,
             16'h1234);
    cmd_pins(OUTPUT_BANK_WRITE_CMD, BANK_LO, 1'b0, 16'hFFA5,
             16'h12A5);
    cmd_pins(OUTPUT_BANK_WRITE_CMD, BANK_HI, 1'b0, 16'hFF3C,
             16'h3CA5);
    cmd_pins(SINGLE_OUTPUT_WRITE_CMD, 4'hD, 1'b0, 16'h0000, 16'h1CA5);
    cmd_pins(SINGLE_OUTPUT_WRITE_CMD, 4'hF, 1'b1, 16'h0000, 16'h9CA5);
    cmd_pins(SINGLE_OUTPUT_WRITE_CMD, 4'h0, 1'b0, 16'h0000, 16'h9CA4);
    rd_chk(ADDR_OUTS, 32'h0000_9CA4, "outs word");
    $display("test outputs done");

    cmd(SAFE_STATE_PROGRAM_CMD, 4'h0, 1'b0, 16'h00F0);
    repeat (10) @(posedge clk);
    cmd(CARD_HARDWARE_RESET_CMD, 4'h0, 1'b0, 16'h0000);
    seen = 1'b0;
    // Drivers are off only in the single boot cycle after the command
    repeat (3) begin
      #1;
      if ((src_oe | snk_oe) === 16'h0000) seen = 1'b1;
      @(posedge clk);
    end
    check_pins({15'h0, seen}, 16'h0001, "drivers off in boot");
    repeat (6) @(posedge clk);
    cmd(RESET_REGISTER_READ_CMD, 4'h0, 1'b0, 16'h0000);
    u_oba_host_model.bus_rd(ADDR_RESULT, d);
    check_word({31'h0, d[0]}, 32'h1, "reset flag");
    #1;
    check_pins(src_oe, 16'h00F0, "new source enables");
    check_pins(snk_oe, 16'hFF0F, "new sink enables");
    cmd(SAFE_STATE_PROGRAM_CMD, 4'h0, 1'b0, 16'h00F0);
    cmd(SINGLE_OUTPUT_WRITE_CMD, 4'h0, 1'b0, 16'h0000);
    rd_chk(ADDR_STATUS, 32'h1 << ST_SKIP, "equal safe word");
    cmd(CAL_WRITE_CMD, 4'h0, 1'b0, 16'h2000);
    repeat (10) @(posedge clk);
    cmd(SINGLE_OUTPUT_WRITE_CMD, 4'h0, 1'b0, 16'h0000);
    rd_chk(ADDR_STATUS, 32'h0000_0000, "cal write accepted");
    $display("test safe state done");

    @(posedge clk);
    adc_raw[1] <= 10'h3FF;
    adc_raw[3] <= 10'h155;
    cmd(CONVERSION_MODE_CMD, 4'h1, 1'b1, 16'h0000);
    u_oba_host_model.bus_rd(ADDR_CONV, d);
    check_word({28'h0, d[3:0]}, 32'h2, "enables");
    conv_read(4'h1, 32'h0000_03FF);
    @(posedge clk);
    adc_ovr[1] <= 1'b1;
    conv_read(4'h1, 32'h0001_F000);
    @(posedge clk);
    adc_ovr[1] <= 1'b0;
    cmd(CONVERSION_MODE_CMD, 4'h3, 1'b1, 16'h0000);
    conv_read(4'h3, 32'h0000_0155);
    cmd(CONVERSION_MODE_CMD, 4'h1, 1'b0, 16'h0000);
    u_oba_host_model.bus_rd(ADDR_CONV, d);
    check_word({28'h0, d[3:0]}, 32'h8, "enables after off");
    check_word({31'h0, diff_seen}, 32'h1, "diff seen");
    $display("test conversions done");
    give_verdict();
  end
endmodule : oba_card_ctrl_tb
